// ==== hw/smsup_pkg.sv ====
package smsup_pkg;

  // ****************************************
  // configuration word layout
  // ****************************************
  localparam int          CFG_W         = 16;
  localparam int          CCP_W         = 8;
  localparam int          CFG_ARM_BIT   = 0;
  localparam int          CFG_CRC_BIT   = 1;
  localparam int          CFG_SWRST_BIT = 2;
  localparam logic [15:0] CFG_RST       = 16'h0000;
  localparam logic [7:0]  CCP_RST       = 8'h00;

  // ****************************************
  // timing
  // ****************************************
  localparam int          CORE_CLK_KHZ  = 50000;
  localparam int          INIT_TIME_US  = 45;
  localparam int          INIT_CYC      = (INIT_TIME_US * CORE_CLK_KHZ + 999) / 1000;
  localparam logic [11:0] INIT_LAST     = 12'(INIT_CYC - 1);
  localparam int          REACT_TIME_US = 20;
  localparam int          REACT_CYC     = REACT_TIME_US * CORE_CLK_KHZ / 1000;
  localparam int          RST_DONE_MS   = 1;
  localparam int          RST_DONE_CYC  = RST_DONE_MS * CORE_CLK_KHZ;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    ST_HOLD  = 2'b00,
    ST_INIT  = 2'b01,
    ST_CHECK = 2'b11,
    ST_RUN   = 2'b10
  } smsup_state_t;

  typedef struct packed {
    logic switch_change_irq;
    logic overvolt_irq_flag;
    logic undervolt_irq_flag;
    logic selfcheck_fail_flag;
    logic por_flag;
  } smsup_irq_t;

  typedef struct packed {
    logic por_flag;
    logic other_irq_spi_flag;
  } smsup_spi_flags_t;

  // comparator levels and pins, all asynchronous to the core clock
  typedef struct packed {
    logic reset_pin;
    logic cs_n;
    logic vdd_ok;
    logic main_supply_good;
    logic main_supply_below_uv_fall;
    logic main_supply_above_uv_rise;
    logic main_supply_above_ov_rise;
    logic main_supply_below_ov_release;
  } smsup_pins_t;

  // synchroniser preset: chip-select idles high, every other level low
  localparam smsup_pins_t PINS_RST = 8'h40;

  typedef struct packed {
    smsup_pins_t      sy0;
    smsup_pins_t      sy1;
    logic             cs_d;
    smsup_state_t     state;
    logic [11:0]      init_cnt;
    logic [CFG_W-1:0] cfg;
    logic [CCP_W-1:0] ccp;
    smsup_irq_t       irq;
    logic             uv_live;
    logic             ov_live;
    logic             wait_base;
    logic             rd_seen;
    logic             int_n;
    smsup_spi_flags_t spi_flags;
    logic             crc_start;
    logic             wetting_en;
    logic             monitor_en;
    logic             poll_restart;
    logic             spi_en;
  } smsup_regs_t;

endpackage : smsup_pkg

// ==== hw/smsup_top.sv ====
`timescale 1ns/1ns
module smsup_top #(
  parameter int P_RST_DONE_CYC = smsup_pkg::RST_DONE_CYC
) (
  input  wire logic                         i_core_clk,
  input  wire logic                         i_srst,
  input  wire smsup_pkg::smsup_pins_t       i_pins,
  input  wire logic                         i_cfg_wr,
  input  wire logic [smsup_pkg::CFG_W-1:0]  i_cfg_wdata,
  input  wire logic                         i_ccp_wr,
  input  wire logic [smsup_pkg::CCP_W-1:0]  i_ccp_wdata,
  input  wire logic                         i_irq_stat_rd,
  input  wire logic                         i_trim_ok,
  input  wire logic                         i_poll_cycle_done,
  output logic                              o_int_n,
  output smsup_pkg::smsup_irq_t             o_irq_stat,
  output smsup_pkg::smsup_spi_flags_t       o_spi_flags,
  output logic                              o_undervolt_live_bit,
  output logic                              o_overvolt_live_bit,
  output logic [smsup_pkg::CFG_W-1:0]       o_cfg,
  output logic [smsup_pkg::CCP_W-1:0]       o_clean_current_cfg_reg,
  output logic                              o_crc_start,
  output logic                              o_wetting_en,
  output logic                              o_monitor_en,
  output logic                              o_poll_restart,
  output logic                              o_spi_en
);
  import smsup_pkg::*;

  // ****************************************
  // state and decoded inputs
  // ****************************************
  smsup_regs_t      r_reg;
  smsup_regs_t      r_next;
  smsup_pins_t      pin;
  logic             hold;
  logic             cs_rise;
  logic             uv_enter;
  logic             uv_exit;
  logic             ov_enter;
  logic             ov_exit;
  logic             running;
  logic             armed;
  logic [CFG_W-1:0] strobe_mask;
  logic [CFG_W-1:0] arm_mask;

  assign pin         = r_reg.sy1;
  assign hold        = pin.reset_pin | ~pin.main_supply_good;
  assign cs_rise     = pin.cs_n & ~r_reg.cs_d;
  assign running     = (r_reg.state == ST_RUN) & ~hold;
  assign armed       = r_reg.cfg[CFG_ARM_BIT];
  assign uv_enter    = running & pin.main_supply_below_uv_fall & ~r_reg.uv_live;
  assign uv_exit     = running & pin.main_supply_above_uv_rise & r_reg.uv_live;
  assign ov_enter    = running & pin.main_supply_above_ov_rise & ~r_reg.ov_live;
  assign ov_exit     = running & pin.main_supply_below_ov_release & r_reg.ov_live;
  assign strobe_mask = CFG_W'((1 << CFG_CRC_BIT) | (1 << CFG_SWRST_BIT));
  assign arm_mask    = CFG_W'(1 << CFG_ARM_BIT);

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    r_next              = r_reg;
    r_next.sy0          = i_pins;
    r_next.sy1          = r_reg.sy0;
    r_next.cs_d         = pin.cs_n;
    r_next.crc_start    = 1'b0;
    r_next.poll_restart = 1'b0;
    case (r_reg.state)
      ST_HOLD: begin
        r_next.state    = ST_INIT;
        r_next.init_cnt = 12'h000;
      end
      ST_INIT: begin
        r_next.init_cnt = r_reg.init_cnt + 12'h001;
        if (r_reg.init_cnt == INIT_LAST) begin
          r_next.state = ST_CHECK;
        end
      end
      ST_CHECK: begin
        r_next.irq.por_flag = 1'b1;
        r_next.irq.selfcheck_fail_flag = ~i_trim_ok;
        r_next.state = ST_RUN;
      end
      ST_RUN: begin
        if (cs_rise) begin
          if (r_reg.rd_seen) begin
            r_next.irq = '0;
          end
          r_next.rd_seen = 1'b0;
        end else if (~pin.cs_n && i_irq_stat_rd) begin
          r_next.rd_seen = 1'b1;
        end
        if (uv_enter) begin
          r_next.uv_live = 1'b1;
          r_next.irq.undervolt_irq_flag = 1'b1;
        end
        if (ov_enter) begin
          r_next.ov_live = 1'b1;
          r_next.irq.overvolt_irq_flag = 1'b1;
        end
        if (uv_exit) begin
          r_next.uv_live = 1'b0;
          r_next.irq.undervolt_irq_flag = 1'b1;
        end
        if (ov_exit) begin
          r_next.ov_live = 1'b0;
          r_next.irq.overvolt_irq_flag = 1'b1;
        end
        if (uv_exit || ov_exit) begin
          r_next.poll_restart = 1'b1;
          r_next.wait_base    = 1'b1;
        end
        if (r_reg.wait_base && i_poll_cycle_done && !r_next.poll_restart) begin
          r_next.wait_base = 1'b0;
          r_next.irq.switch_change_irq = 1'b1;
        end
        if (i_cfg_wr) begin
          if (armed) begin
            r_next.cfg = (r_reg.cfg & ~arm_mask) | (i_cfg_wdata & arm_mask);
          end else begin
            r_next.cfg = i_cfg_wdata & ~strobe_mask;
          end
          r_next.crc_start = i_cfg_wdata[CFG_CRC_BIT];
        end
        // clean-current register is writable at any time in run state, armed or not
        if (i_ccp_wr) begin
          r_next.ccp = i_ccp_wdata;
        end
        if (i_cfg_wr && i_cfg_wdata[CFG_SWRST_BIT]) begin
          r_next.state     = ST_INIT;
          r_next.init_cnt  = 12'h000;
          r_next.crc_start = 1'b0;
        end
      end
      default: begin
        r_next.state = ST_HOLD;
      end
    endcase
    if (hold || r_next.state != ST_RUN) begin
      r_next.cfg       = CFG_RST;
      r_next.ccp       = CCP_RST;
      r_next.uv_live   = 1'b0;
      r_next.ov_live   = 1'b0;
      r_next.wait_base = 1'b0;
      r_next.rd_seen   = 1'b0;
      if (r_next.state != ST_CHECK && r_reg.state != ST_CHECK) begin
        r_next.irq = '0;
      end
    end
    if (hold) begin
      r_next.state     = ST_HOLD;
      r_next.irq       = '0;
      r_next.crc_start = 1'b0;
      r_next.poll_restart = 1'b0;
    end
    // pin follows flags in the same cycle
    r_next.int_n = ~(|r_next.irq);
    r_next.spi_flags.other_irq_spi_flag =
      r_next.irq.undervolt_irq_flag | r_next.irq.overvolt_irq_flag;
    r_next.spi_flags.por_flag = r_next.irq.por_flag;
    // currents only armed and fault free
    r_next.wetting_en = (r_next.state == ST_RUN) & r_next.cfg[CFG_ARM_BIT]
                        & ~r_next.uv_live & ~r_next.ov_live;
    r_next.monitor_en = r_next.wetting_en;
    // serial side needs logic supply and any state but hold
    r_next.spi_en = (r_next.state != ST_HOLD) & pin.vdd_ok;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      r_reg       <= '0;
      r_reg.int_n <= 1'b1;
      r_reg.sy0   <= PINS_RST;
      r_reg.sy1   <= PINS_RST;
      r_reg.cs_d  <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign o_int_n                 = r_reg.int_n;
  assign o_irq_stat              = r_reg.irq;
  assign o_spi_flags             = r_reg.spi_flags;
  assign o_undervolt_live_bit    = r_reg.uv_live;
  assign o_overvolt_live_bit     = r_reg.ov_live;
  assign o_cfg                   = r_reg.cfg;
  assign o_clean_current_cfg_reg = r_reg.ccp;
  assign o_crc_start             = r_reg.crc_start;
  assign o_wetting_en            = r_reg.wetting_en;
  assign o_monitor_en            = r_reg.monitor_en;
  assign o_poll_restart          = r_reg.poll_restart;
  assign o_spi_en                = r_reg.spi_en;

  // ****************************************
  // assertions
  // ****************************************
  localparam int REACT_MAX = REACT_CYC;
  logic [CFG_W-1:0] cfg_locked;
  logic [31:0]      busy_cnt;
  logic             plain_run;
  assign cfg_locked = r_reg.cfg & ~arm_mask;
  assign plain_run  = running & ~i_cfg_wr;

  always_ff @(posedge i_core_clk) begin
    if (i_srst || r_reg.state == ST_RUN || hold) begin
      busy_cnt <= 32'h00000000;
    end else begin
      busy_cnt <= busy_cnt + 32'h00000001;
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);

  sequence uv_entry_s;
    plain_run && uv_enter;
  endsequence
  sequence uv_done_s;
    o_undervolt_live_bit && o_irq_stat.undervolt_irq_flag && !o_int_n;
  endsequence
  sequence recover_s;
    plain_run && (uv_exit || ov_exit);
  endsequence

  AST_HOLD_CLEARS: assert property (hold |=> o_irq_stat == '0 && !o_monitor_en && !o_spi_en)
    else $error("hold state left flags or outputs active");
  AST_POR_FLAG: assert property (r_reg.state == ST_CHECK && !hold
      |=> o_irq_stat.por_flag && o_spi_flags.por_flag && !o_int_n)
    else $error("power-on flag not raised after init");
  AST_CHECK_FAIL: assert property (r_reg.state == ST_CHECK && !hold && !i_trim_ok
      |=> o_irq_stat.selfcheck_fail_flag && o_irq_stat.por_flag)
    else $error("self-check failure not flagged");
  AST_CFG_LOCK: assert property (armed && plain_run ##1 armed |-> cfg_locked == $past(cfg_locked))
    else $error("locked configuration changed while armed");
  AST_UV_ENTER: assert property (uv_entry_s |=> uv_done_s ##0 !o_wetting_en)
    else $error("under-voltage entry not reported");
  AST_OV_ENTER: assert property (plain_run && ov_enter
      |=> o_overvolt_live_bit && o_irq_stat.overvolt_irq_flag && !o_monitor_en)
    else $error("over-voltage entry not reported");
  AST_OTHER_FLAG: assert property (o_spi_flags.other_irq_spi_flag
      == (o_irq_stat.undervolt_irq_flag | o_irq_stat.overvolt_irq_flag))
    else $error("other-interrupt flag mismatch");
  AST_KEEP_UNREAD: assert property (plain_run && cs_rise && !r_reg.rd_seen
      |=> (o_irq_stat & $past(o_irq_stat)) == $past(o_irq_stat))
    else $error("status cleared without a read");
  AST_RECOVER: assert property (recover_s |=> o_poll_restart && !o_int_n)
    else $error("recovery did not restart polling");
  AST_NO_REPEAT: assert property (plain_run && r_reg.uv_live && !pin.main_supply_above_uv_rise
      |=> !$rose(o_irq_stat.undervolt_irq_flag))
    else $error("repeated under-voltage interrupt");
  AST_REACT: assert property (uv_entry_s |-> ##[1:REACT_MAX] !o_int_n)
    else $error("interrupt pin late after fault");
  AST_RESET_TIME: assert property (busy_cnt < P_RST_DONE_CYC)
    else $error("reset took too long");
  AST_SPI_FAULT: assert property (plain_run && r_reg.uv_live && pin.vdd_ok |=> o_spi_en)
    else $error("serial side dropped during fault");

endmodule : smsup_top

// ==== verification/smsup_host_model.sv ====
`timescale 1ns/1ns
module smsup_host_model (
  input  wire logic i_core_clk,
  output logic      o_cs_n,
  output logic      o_irq_stat_rd
);
  initial begin
    o_cs_n        = 1'b1;
    o_irq_stat_rd = 1'b0;
  end
  // ****************************************
  // one serial frame, 8 link clocks of 160 ns each side of the read
  // ****************************************
  task automatic frame(input logic rd);
    @(negedge i_core_clk);
    o_cs_n = 1'b0;
    repeat (64) @(negedge i_core_clk);
    o_irq_stat_rd = rd;
    @(negedge i_core_clk);
    o_irq_stat_rd = 1'b0;
    repeat (64) @(negedge i_core_clk);
    o_cs_n = 1'b1;
    // inter-frame gap also leaves room for the synced clear to land
    repeat (75) @(negedge i_core_clk);
  endtask : frame
endmodule : smsup_host_model

// ==== verification/smsup_top_bench.sv ====
`timescale 1ns/1ns
module smsup_top_bench;
  import smsup_pkg::*;
  localparam int RST_CYC = 3000;
  localparam int LIMIT   = 40000;
  logic                 clk = 1'b0;
  logic                 srst = 1'b1;
  smsup_pins_t          pins;
  smsup_pins_t          pin_drv;
  logic                 cs_n;
  logic                 irq_rd;
  logic                 cfg_wr = 1'b0;
  logic [CFG_W-1:0]     cfg_wdata = '0;
  logic                 ccp_wr = 1'b0;
  logic [CCP_W-1:0]     ccp_wdata = '0;
  logic                 trim_ok = 1'b1;
  logic                 poll_done = 1'b0;
  logic                 o_int_n;
  smsup_irq_t           o_irq_stat;
  smsup_spi_flags_t     o_spi_flags;
  logic                 uv_live;
  logic                 ov_live;
  logic [CFG_W-1:0]     o_cfg;
  logic [CCP_W-1:0]     o_ccp;
  logic                 o_crc_start;
  logic                 o_wet;
  logic                 o_mon;
  logic                 o_poll_restart;
  logic                 o_spi_en;
  int                   bad_count = 0;
  int                   checks = 0;
  int                   cyc = 0;
  int                   crc_cnt = 0;
  int                   rst_cnt = 0;

  always #10 clk = ~clk;
  initial pins = '{reset_pin: 1'b0, cs_n: 1'b1, vdd_ok: 1'b1, main_supply_good: 1'b0,
                   main_supply_below_uv_fall: 1'b0, main_supply_above_uv_rise: 1'b1,
                   main_supply_above_ov_rise: 1'b0, main_supply_below_ov_release: 1'b1};
  always_comb begin
    pin_drv      = pins;
    pin_drv.cs_n = cs_n;
  end

  smsup_host_model u_host (.i_core_clk(clk), .o_cs_n(cs_n), .o_irq_stat_rd(irq_rd));
  smsup_top #(.P_RST_DONE_CYC(RST_CYC)) u_dut (
    .i_core_clk(clk), .i_srst(srst), .i_pins(pin_drv), .i_cfg_wr(cfg_wr),
    .i_cfg_wdata(cfg_wdata), .i_ccp_wr(ccp_wr), .i_ccp_wdata(ccp_wdata),
    .i_irq_stat_rd(irq_rd), .i_trim_ok(trim_ok), .i_poll_cycle_done(poll_done),
    .o_int_n(o_int_n), .o_irq_stat(o_irq_stat), .o_spi_flags(o_spi_flags),
    .o_undervolt_live_bit(uv_live), .o_overvolt_live_bit(ov_live), .o_cfg(o_cfg),
    .o_clean_current_cfg_reg(o_ccp), .o_crc_start(o_crc_start), .o_wetting_en(o_wet),
    .o_monitor_en(o_mon), .o_poll_restart(o_poll_restart), .o_spi_en(o_spi_en));

  // ****************************************
  // pulse counters and hang guard
  // ****************************************
  always @(negedge clk) begin
    if (o_crc_start === 1'b1) crc_cnt++;
    if (o_poll_restart === 1'b1) rst_cnt++;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      bad_count++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      bad_count++;
    end
  endtask : chk

  task automatic wait_int(input int lim);
    for (int i = 0; i < lim && o_int_n !== 1'b0; i++) @(negedge clk);
    @(negedge clk);
  endtask : wait_int

  task automatic wr_cfg(input logic [15:0] d);
    @(negedge clk);
    cfg_wdata = d;
    cfg_wr    = 1'b1;
    @(negedge clk);
    cfg_wr = 1'b0;
    repeat (2) @(negedge clk);
  endtask : wr_cfg

  task automatic set_fault(input logic ov, input logic on);
    @(negedge clk);
    if (ov) begin
      pins.main_supply_above_ov_rise    = on;
      pins.main_supply_below_ov_release = !on;
    end else begin
      pins.main_supply_below_uv_fall = on;
      pins.main_supply_above_uv_rise = !on;
    end
  endtask : set_fault

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_por();
    repeat (100) @(negedge clk);
    chk(16'({o_spi_en, o_int_n}), 16'h0001);
    pins.main_supply_good = 1'b1;
    wait_int(RST_CYC);
    chk(16'(o_int_n), 16'h0000);
    chk(16'(o_irq_stat), 16'h0001);
    chk(16'(o_spi_flags.por_flag), 16'h0001);
    chk(o_cfg, CFG_RST);
    u_host.frame(1'b0);
    chk(16'(o_int_n), 16'h0000);
    u_host.frame(1'b1);
    chk(16'({o_int_n, o_irq_stat}), 16'h0020);
    $display("test por done");
  endtask : t_por

  task automatic t_cfg();
    int n;
    wr_cfg(16'h0008);
    chk(o_cfg, 16'h0008);
    chk(16'({o_wet, o_mon}), 16'h0000);
    wr_cfg(16'h0009);
    chk(16'({o_wet, o_mon}), 16'h0003);
    n = crc_cnt;
    wr_cfg(16'h00F3);
    repeat (2) @(negedge clk);
    chk(o_cfg, 16'h0009);
    chk(16'(crc_cnt - n), 16'h0001);
    @(negedge clk);
    ccp_wdata = 8'h5A;
    ccp_wr    = 1'b1;
    @(negedge clk);
    ccp_wr = 1'b0;
    @(negedge clk);
    chk(16'(o_ccp), 16'h005A);
    wr_cfg(16'h0000);
    chk(16'({o_wet, o_mon}), 16'h0000);
    wr_cfg(16'h0030);
    chk(o_cfg, 16'h0030);
    wr_cfg(16'h0000);
    $display("test cfg done");
  endtask : t_cfg

  task automatic t_fault(input logic ov);
    int n;
    logic [15:0] flag;
    flag = ov ? 16'h0008 : 16'h0004;
    wr_cfg(16'h0001);
    set_fault(ov, 1'b1);
    wait_int(1000);
    chk(16'(o_int_n), 16'h0000);
    chk(16'({uv_live, ov_live}), ov ? 16'h0001 : 16'h0002);
    chk(16'(o_irq_stat), flag);
    chk(16'({o_wet, o_mon}), 16'h0000);
    chk(16'(o_spi_flags.other_irq_spi_flag), 16'h0001);
    chk({o_spi_en, o_cfg[14:0]}, 16'h8001);
    u_host.frame(1'b1);
    repeat (50) @(negedge clk);
    chk(16'({o_int_n, o_irq_stat}), 16'h0020);
    n = rst_cnt;
    set_fault(ov, 1'b0);
    wait_int(1000);
    chk(16'({o_int_n, uv_live, ov_live}), 16'h0000);
    chk(16'(o_irq_stat), flag);
    chk(16'(rst_cnt - n), 16'h0001);
    chk(16'({o_wet, o_mon}), 16'h0003);
    poll_done = 1'b1;
    @(negedge clk);
    poll_done = 1'b0;
    repeat (2) @(negedge clk);
    chk(16'(o_irq_stat), flag | 16'h0010);
    u_host.frame(1'b1);
    chk(16'(o_irq_stat), 16'h0000);
    wr_cfg(16'h0000);
    $display("test fault done");
  endtask : t_fault

  task automatic t_swrst();
    wr_cfg(16'h0009);
    trim_ok = 1'b0;
    wr_cfg(16'h0004);
    chk(16'({o_int_n, o_cfg[14:0]}), 16'h8000);
    wait_int(RST_CYC);
    chk(16'(o_irq_stat), 16'h0003);
    // host reloads trim after a failed check
    trim_ok = 1'b1;
    wr_cfg(16'h0004);
    repeat (10) @(negedge clk);
    chk(16'(o_int_n), 16'h0001);
    wait_int(RST_CYC);
    chk(16'(o_irq_stat), 16'h0001);
    chk(16'(o_spi_flags.por_flag), 16'h0001);
    $display("test swrst done");
  endtask : t_swrst

  task automatic t_hwrst();
    // pin held high 2 us with the power-on status still pending
    pins.reset_pin = 1'b1;
    repeat (100) @(negedge clk);
    chk(16'({o_spi_en, o_irq_stat, o_cfg[9:0]}), 16'h0000);
    chk(16'(o_int_n), 16'h0001);
    pins.reset_pin = 1'b0;
    wait_int(RST_CYC);
    chk(16'({o_int_n, o_irq_stat}), 16'h0001);
    u_host.frame(1'b1);
    $display("test hwrst done");
  endtask : t_hwrst

  task automatic t_supply();
    wr_cfg(16'h0009);
    pins.vdd_ok = 1'b0;
    repeat (10) @(negedge clk);
    chk({o_spi_en, o_cfg[14:0]}, 16'h0009);
    pins.vdd_ok           = 1'b1;
    pins.main_supply_good = 1'b0;
    repeat (10) @(negedge clk);
    chk({o_spi_en, o_cfg[14:0]}, 16'h0000);
    pins.main_supply_good = 1'b1;
    wait_int(RST_CYC);
    chk(16'({o_int_n, o_irq_stat}), 16'h0001);
    $display("test supply done");
  endtask : t_supply

  initial begin
    repeat (10) @(negedge clk);
    srst = 1'b0;
    t_por();
    t_cfg();
    t_fault(1'b0);
    t_fault(1'b1);
    t_swrst();
    t_hwrst();
    t_supply();
    report_and_stop();
  end
endmodule : smsup_top_bench
